// File: pgs_regs.vh
// Offsets, field positions, reset values and codes of the gigabit status and indirect access registers.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef PGS_REGS_VH
`define PGS_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PGS_OFF_GIG_STATUS 5'h0A
`define PGS_OFF_ACCESS_CTRL 5'h0D
`define PGS_OFF_WINDOW 5'h0E
`define PGS_OFF_EXT_STATUS 5'h0F

// ----------------------------------------------------------------------------
// Gigabit link status fields
// ----------------------------------------------------------------------------
`define PGS_GS_FAULT_BIT 15
`define PGS_GS_MASTER_BIT 14
`define PGS_GS_LOCAL_OK_BIT 13
`define PGS_GS_REMOTE_OK_BIT 12
`define PGS_GS_LP_FULL_BIT 11
`define PGS_GS_LP_HALF_BIT 10
`define PGS_GS_RSVD_VALUE 2'h0
`define PGS_IDLE_ERR_RESET 8'h00
`define PGS_IDLE_ERR_MAX 8'hFF
`define PGS_IDLE_ERR_ONE 8'h01

// ----------------------------------------------------------------------------
// Indirect access control fields and modes
// ----------------------------------------------------------------------------
`define PGS_CTRL_MODE_HI 15
`define PGS_CTRL_MODE_LO 14
`define PGS_CTRL_DEV_HI 4
`define PGS_CTRL_DEV_LO 0
`define PGS_CTRL_RESET 16'h0000
`define PGS_MODE_ADDRESS 2'h0
`define PGS_MODE_DATA_NOINC 2'h1
`define PGS_MODE_DATA_INC_RW 2'h2
`define PGS_MODE_DATA_INC_WR 2'h3
`define PGS_WINDOW_RESET 16'h0000
`define PGS_ADDR_STEP 16'h0001

// ----------------------------------------------------------------------------
// Extended status and miscellaneous values
// ----------------------------------------------------------------------------
`define PGS_EXT_STATUS_VALUE 16'h3000
`define PGS_UNMAPPED_VALUE 16'h0000
`define PGS_STORE_RESET 16'h0000
`define PGS_STORE_DEPTH 32

`endif

// File: pgs_sync3.v
// Three-stage input synchroniser with an agreement filter per bit.
// Assumes every bit of din is asynchronous to clk and may be sampled independently.
`timescale 1ns/1ps

module pgs_sync3 #(
  parameter W = 1
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  wire [W-1:0] agree;

  // A bit changes only once stages two and three hold the same value.
  assign agree = ~(stage2 ^ stage3);

  always @(posedge clk) begin
    if (srst) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout <= (dout & ~agree) | (stage3 & agree);
    end
  end

endmodule // pgs_sync3

// File: pgs_ext_store.v
// Flip-flop storage for the extended device registers reached through the indirect window.
// Assumes one write port and one combinational read port on the same index space.
`timescale 1ns/1ps
`include "pgs_regs.vh"

module pgs_ext_store (
  input wire clk,
  input wire srst,
  input wire writeEn,
  input wire [4:0] index,
  input wire [15:0] writeData,
  output wire [15:0] readData
);

  reg [15:0] mem [0:`PGS_STORE_DEPTH-1];
  integer i;

  assign readData = mem[index];

  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < `PGS_STORE_DEPTH; i = i + 1) begin
        mem[i] <= `PGS_STORE_RESET;
      end
    end else if (writeEn) begin
      mem[index] <= writeData;
    end
  end

endmodule // pgs_ext_store

// File: pgs_phy_gig_status.v
// Gigabit status, indirect extended-register access and extended status registers of a transceiver.
// Assumes a management front end that turns frames into one-cycle read and write strobes on clk,
// and link-side status levels plus the symbol clock arriving asynchronously on pins.
`timescale 1ns/1ps
`include "pgs_regs.vh"

module pgs_phy_gig_status (
  input wire clk,
  input wire srst,
  input wire regRead,
  input wire regWrite,
  input wire [4:0] regAddr,
  input wire [15:0] regWdata,
  output reg [15:0] regRdata,
  output reg regAck,
  input wire symbolClk,
  input wire masterResolved,
  input wire localRcvrOk,
  input wire remoteRcvrOk,
  input wire partnerFullCap,
  input wire partnerHalfCap,
  input wire rxIdle,
  input wire transmitModeIndication,
  input wire rxErrorStatus,
  input wire configFault
);

  // --------------------------------------------------------------------------
  // Link-side input conditioning
  // --------------------------------------------------------------------------
  localparam LNK_W = 10;
  localparam LNK_SYM = 0;
  localparam LNK_MASTER = 1;
  localparam LNK_LOCAL = 2;
  localparam LNK_REMOTE = 3;
  localparam LNK_LP_FULL = 4;
  localparam LNK_LP_HALF = 5;
  localparam LNK_IDLE = 6;
  localparam LNK_TXMODE = 7;
  localparam LNK_RXERR = 8;
  localparam LNK_FAULT = 9;

  wire [LNK_W-1:0] linkRaw;
  wire [LNK_W-1:0] linkClean;
  reg symPrev;
  wire symEdge;
  wire idleErrorEvent;

  assign linkRaw = {configFault, rxErrorStatus, transmitModeIndication, rxIdle, partnerHalfCap,
                    partnerFullCap, remoteRcvrOk, localRcvrOk, masterResolved, symbolClk};

  // Every link pin, the symbol clock included, crosses through one filter so they stay aligned.
  pgs_sync3 #(
    .W(LNK_W)
  ) u_link_sync (
    .clk(clk),
    .srst(srst),
    .din(linkRaw),
    .dout(linkClean)
  );

  always @(posedge clk) begin
    if (srst) begin
      symPrev <= 1'b0;
    end else begin
      symPrev <= linkClean[LNK_SYM];
    end
  end

  // One rising edge of the filtered symbol clock marks one symbol period.
  assign symEdge = linkClean[LNK_SYM] & ~symPrev;

  // The status levels are sampled together with the error flag at the symbol edge.
  assign idleErrorEvent = symEdge & linkClean[LNK_IDLE] & linkClean[LNK_TXMODE]
                          & linkClean[LNK_RXERR];

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  // A write strobe wins over a read strobe raised in the same cycle.
  wire isWrite;
  wire isRead;
  wire hitStatus;
  wire hitCtrl;
  wire hitWindow;
  wire hitExt;
  wire readStatus;
  wire windowData;
  wire windowWrite;
  wire windowRead;

  assign isWrite = regWrite;
  assign isRead = regRead & ~regWrite;
  assign hitStatus = (regAddr == `PGS_OFF_GIG_STATUS);
  assign hitCtrl = (regAddr == `PGS_OFF_ACCESS_CTRL);
  assign hitWindow = (regAddr == `PGS_OFF_WINDOW);
  assign hitExt = (regAddr == `PGS_OFF_EXT_STATUS);
  assign readStatus = isRead & hitStatus;

  // --------------------------------------------------------------------------
  // Gigabit link status
  // --------------------------------------------------------------------------
  reg faultFlag;
  reg [7:0] idleErrCount;
  reg [7:0] next_idleErrCount;
  reg next_faultFlag;
  wire [15:0] statusWord;

  // Holding at the top keeps a long error burst from reading back as a small count.
  function [7:0] pgs_sat_inc;
    input [7:0] count;
    begin
      if (count == `PGS_IDLE_ERR_MAX) begin
        pgs_sat_inc = count;
      end else begin
        pgs_sat_inc = count + `PGS_IDLE_ERR_ONE;
      end
    end
  endfunction

  // A new event in the cycle of the clearing read survives: set wins over clear.
  always @* begin
    next_faultFlag = faultFlag;
    if (linkClean[LNK_FAULT]) begin
      next_faultFlag = 1'b1;
    end else if (readStatus) begin
      next_faultFlag = 1'b0;
    end
  end

  always @* begin
    next_idleErrCount = idleErrCount;
    if (readStatus) begin
      // The read returns the old count; an event arriving with it starts the next count.
      if (idleErrorEvent) begin
        next_idleErrCount = `PGS_IDLE_ERR_ONE;
      end else begin
        next_idleErrCount = `PGS_IDLE_ERR_RESET;
      end
    end else if (idleErrorEvent) begin
      next_idleErrCount = pgs_sat_inc(idleErrCount);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      faultFlag <= 1'b0;
      idleErrCount <= `PGS_IDLE_ERR_RESET;
    end else begin
      faultFlag <= next_faultFlag;
      idleErrCount <= next_idleErrCount;
    end
  end

  assign statusWord = {faultFlag,
                       linkClean[LNK_MASTER],
                       linkClean[LNK_LOCAL],
                       linkClean[LNK_REMOTE],
                       linkClean[LNK_LP_FULL],
                       linkClean[LNK_LP_HALF],
                       `PGS_GS_RSVD_VALUE,
                       idleErrCount};

  // --------------------------------------------------------------------------
  // Indirect access control and window
  // --------------------------------------------------------------------------
  reg [15:0] accessCtrl;
  reg [15:0] heldAddr;
  reg [15:0] next_heldAddr;
  wire [1:0] accessMode;
  wire [4:0] deviceAddr;
  wire [4:0] storeIndex;
  wire [15:0] storeRdata;
  wire storeWrite;
  wire stepAddr;

  // The store is smaller than the full address space, so device and register addresses alias.
  function [4:0] pgs_index;
    input [4:0] dev;
    input [15:0] addr;
    begin
      pgs_index = {dev[1:0], addr[2:0]};
    end
  endfunction

  // Post-increment applies to data accesses only; address mode loads the pointer instead.
  function pgs_step;
    input [1:0] mode;
    input wr;
    input rd;
    begin
      if (mode == `PGS_MODE_DATA_INC_RW) begin
        pgs_step = wr | rd;
      end else if (mode == `PGS_MODE_DATA_INC_WR) begin
        pgs_step = wr;
      end else begin
        pgs_step = 1'b0;
      end
    end
  endfunction

  assign accessMode = accessCtrl[`PGS_CTRL_MODE_HI:`PGS_CTRL_MODE_LO];
  assign deviceAddr = accessCtrl[`PGS_CTRL_DEV_HI:`PGS_CTRL_DEV_LO];
  assign windowData = (accessMode != `PGS_MODE_ADDRESS);
  assign windowWrite = isWrite & hitWindow;
  assign windowRead = isRead & hitWindow;
  assign storeWrite = windowWrite & windowData;
  assign storeIndex = pgs_index(deviceAddr, heldAddr);

  assign stepAddr = pgs_step(accessMode, windowWrite, windowRead);

  always @* begin
    next_heldAddr = heldAddr;
    if (windowWrite && !windowData) begin
      next_heldAddr = regWdata;
    end else if (stepAddr) begin
      next_heldAddr = heldAddr + `PGS_ADDR_STEP;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      accessCtrl <= `PGS_CTRL_RESET;
      heldAddr <= `PGS_WINDOW_RESET;
    end else begin
      if (isWrite && hitCtrl) begin
        accessCtrl <= regWdata;
      end
      heldAddr <= next_heldAddr;
    end
  end

  pgs_ext_store u_ext_store (
    .clk(clk),
    .srst(srst),
    .writeEn(storeWrite),
    .index(storeIndex),
    .writeData(regWdata),
    .readData(storeRdata)
  );

  // --------------------------------------------------------------------------
  // Read data and acknowledge
  // --------------------------------------------------------------------------
  // Unmapped offsets read as zero so a scan of the space sees clean holes.
  reg [15:0] next_regRdata;

  always @* begin
    next_regRdata = regRdata;
    if (isRead) begin
      if (hitStatus) begin
        next_regRdata = statusWord;
      end else if (hitCtrl) begin
        next_regRdata = accessCtrl;
      end else if (hitWindow) begin
        if (windowData) begin
          next_regRdata = storeRdata;
        end else begin
          next_regRdata = heldAddr;
        end
      end else if (hitExt) begin
        next_regRdata = `PGS_EXT_STATUS_VALUE;
      end else begin
        next_regRdata = `PGS_UNMAPPED_VALUE;
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      regRdata <= `PGS_UNMAPPED_VALUE;
      regAck <= 1'b0;
    end else begin
      regRdata <= next_regRdata;
      // Every strobe is acknowledged, mapped or not, so the controller never waits on a hole.
      regAck <= isRead | isWrite;
    end
  end

endmodule // pgs_phy_gig_status

// File: pgs_status_props.sv
// Concurrent checks on the gigabit status block's register port and status pins.
// Assumes the bind below and status pins that stay steady around reads.
`timescale 1ns/1ps
module pgs_status_props (
  input wire clk,
  input wire srst,
  input wire regRead,
  input wire regWrite,
  input wire [4:0] regAddr,
  input wire [15:0] regRdata,
  input wire regAck,
  input wire masterResolved,
  input wire localRcvrOk,
  input wire remoteRcvrOk,
  input wire partnerFullCap,
  input wire partnerHalfCap,
  input wire rxIdle
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // The pin filter needs up to four cycles, so a level must hold eight cycles before it is judged.
  wire rdA = regRead && !regWrite && regAddr == 5'h0A;
  wire rdF = regRead && !regWrite && regAddr == 5'h0F;
  property p_ack; (regRead || regWrite) |=> regAck; endproperty
  a_ack: assert property (p_ack) else $error("strobe not acknowledged");
  property p_master; $stable(masterResolved)[*8] ##0 rdA |=> regRdata[14] == $past(masterResolved); endproperty
  a_master: assert property (p_master) else $error("master bit wrong");
  property p_local; $stable(localRcvrOk)[*8] ##0 rdA |=> regRdata[13] == $past(localRcvrOk); endproperty
  a_local: assert property (p_local) else $error("local status bit wrong");
  property p_remote; $stable(remoteRcvrOk)[*8] ##0 rdA |=> regRdata[12] == $past(remoteRcvrOk); endproperty
  a_remote: assert property (p_remote) else $error("remote status bit wrong");
  property p_lpfull; $stable(partnerFullCap)[*8] ##0 rdA |=> regRdata[11] == $past(partnerFullCap); endproperty
  a_lpfull: assert property (p_lpfull) else $error("partner full bit wrong");
  property p_lphalf; $stable(partnerHalfCap)[*8] ##0 rdA |=> regRdata[10] == $past(partnerHalfCap); endproperty
  a_lphalf: assert property (p_lphalf) else $error("partner half bit wrong");
  property p_rsvd; rdA |=> regRdata[9:8] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
  property p_idle; (!rxIdle)[*6] ##0 rdA ##1 (!rxIdle)[*8] ##0 rdA |=> regRdata[7:0] == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("count moved without idles");
  property p_clear; rdA ##2 rdA |=> regRdata[7:0] <= 8'h01; endproperty
  a_clear: assert property (p_clear) else $error("count not cleared by read");
  property p_ext; rdF |=> regRdata[15:12] == 4'h3; endproperty
  a_ext: assert property (p_ext) else $error("extended status wrong");
  c_rd: cover property (rdA ##2 rdA);
  c_win: cover property (regWrite && regAddr == 5'h0E);
  c_ext: cover property (rdF);
endmodule // pgs_status_props

bind pgs_phy_gig_status pgs_status_props i_pgs_status_props (.clk, .srst, .regRead, .regWrite, .regAddr,
  .regRdata, .regAck, .masterResolved, .localRcvrOk, .remoteRcvrOk, .partnerFullCap, .partnerHalfCap, .rxIdle);

// File: pgs_mgmt_model.sv
// Station management controller model issuing one-cycle register strobes.
// Assumes the acknowledge arrives one cycle after the strobe is taken.
`timescale 1ns/1ps
module pgs_mgmt_model (
  input wire clk,
  input wire regAck,
  input wire [15:0] regRdata,
  output logic regRead = 1'b0,
  output logic regWrite = 1'b0,
  output logic [4:0] regAddr = 5'h00,
  output logic [15:0] regWdata = 16'h0000
);
  // ----
  // Access task
  // ----
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q,
    output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    @(negedge clk);
    regWrite = w;
    regRead = !w;
    regAddr = a;
    regWdata = d;
    // The strobe is a one-cycle pulse; ack and read data stand until the next edge, so take them mid-cycle.
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk);
      if (i == 0) begin
        regRead = 1'b0;
        regWrite = 1'b0;
      end
      if (regAck === 1'b1) begin
        ok = 1'b1;
        q = regRdata;
      end
    end
    // Released lines show the inverse so a stale value is never read by luck.
    regAddr = ~a;
    regWdata = ~d;
  endtask
endmodule // pgs_mgmt_model

// File: pgs_tb.sv
// Self-checking bench for the gigabit status and indirect access registers.
// Assumes the management model drives the register port and the bench drives the link pins.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, srst = 1'b1, symbolClk = 1'b0, masterResolved = 1'b0, localRcvrOk = 1'b0;
  logic remoteRcvrOk = 1'b0, partnerFullCap = 1'b0, partnerHalfCap = 1'b0, rxIdle = 1'b0;
  logic transmitModeIndication = 1'b0, rxErrorStatus = 1'b0, configFault = 1'b0;
  logic regRead, regWrite, regAck;
  logic [4:0] regAddr;
  logic [15:0] regWdata, regRdata;
  int mismatches = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  pgs_phy_gig_status i_pgs_phy_gig_status (.clk, .srst, .regRead, .regWrite, .regAddr, .regWdata, .regRdata,
    .regAck, .symbolClk, .masterResolved, .localRcvrOk, .remoteRcvrOk, .partnerFullCap, .partnerHalfCap,
    .rxIdle, .transmitModeIndication, .rxErrorStatus, .configFault);
  pgs_mgmt_model i_pgs_mgmt_model (.clk, .regAck, .regRdata, .regRead, .regWrite, .regAddr, .regWdata);
  // ----
  // Helpers
  // ----
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    logic ok;
    i_pgs_mgmt_model.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] ack expected 1 seen %b", ok);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    acc(1'b1, a, d, q);
  endtask
  // Only the bits under the mask are judged, so reserved fields can be ignored.
  task automatic rd(input string n, input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
    acc(1'b0, a, 16'h0000, q);
    checked++;
    if ((q & m) !== (e & m)) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e & m, q & m);
    end
  endtask
  task automatic pins(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic symbols(input int n);
    #7;
    repeat (n) begin
      #100 symbolClk = 1'b1;
      #100 symbolClk = 1'b0;
    end
    pins(8);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    wr(5'h0A, 16'hFFFF);
    wr(5'h0F, 16'hFFFF);
    rd("status", 5'h0A, 16'hFFFF, 16'h0000);
    pins(6);
    rd("status quiet", 5'h0A, 16'h00FF, 16'h0000);
    rd("control", 5'h0D, 16'hFFFF, 16'h0000);
    rd("window", 5'h0E, 16'hFFFF, 16'h0000);
    rd("ext status", 5'h0F, 16'hF000, 16'h3000);
    rd("unmapped", 5'h01, 16'hFFFF, 16'h0000);
  endtask
  task automatic t_status();
    for (int k = 0; k < 2; k++) begin
      pins(1);
      {masterResolved, localRcvrOk, remoteRcvrOk, partnerFullCap, partnerHalfCap} = k ? 5'h0D : 5'h12;
      pins(8);
      rd("flags", 5'h0A, 16'h7F00, k ? 16'h3400 : 16'h4800);
    end
  endtask
  task automatic t_window();
    wr(5'h0D, 16'h3FE1);
    rd("control rw", 5'h0D, 16'hFFFF, 16'h3FE1);
    wr(5'h0E, 16'h0008);
    rd("held addr", 5'h0E, 16'hFFFF, 16'h0008);
    wr(5'h0D, 16'hC001);
    wr(5'h0E, 16'h1111);
    wr(5'h0E, 16'h2222);
    wr(5'h0D, 16'h0001);
    rd("addr after writes", 5'h0E, 16'hFFFF, 16'h000A);
    wr(5'h0E, 16'h0008);
    wr(5'h0D, 16'h8001);
    rd("inc read 0", 5'h0E, 16'hFFFF, 16'h1111);
    rd("inc read 1", 5'h0E, 16'hFFFF, 16'h2222);
    wr(5'h0D, 16'h4001);
    wr(5'h0E, 16'h3333);
    rd("no inc", 5'h0E, 16'hFFFF, 16'h3333);
    wr(5'h0D, 16'hC001);
    rd("wr-only read", 5'h0E, 16'hFFFF, 16'h3333);
    wr(5'h0D, 16'h0001);
    rd("final addr", 5'h0E, 16'hFFFF, 16'h000A);
  endtask
  task automatic t_idle();
    pins(1);
    {rxIdle, transmitModeIndication, rxErrorStatus} = 3'h7;
    pins(8);
    rd("pre-clear", 5'h0A, 16'h00FF, 16'h0000);
    symbols(3);
    rd("idle errors", 5'h0A, 16'h00FF, 16'h0003);
    rd("cleared", 5'h0A, 16'h00FF, 16'h0000);
    transmitModeIndication = 1'b0;
    pins(8);
    symbols(3);
    rd("wrong mode", 5'h0A, 16'h00FF, 16'h0000);
    transmitModeIndication = 1'b1;
    pins(8);
    symbols(260);
    rd("saturated", 5'h0A, 16'h00FF, 16'h00FF);
  endtask
  task automatic t_fault();
    configFault = 1'b1;
    pins(8);
    configFault = 1'b0;
    pins(8);
    rd("fault latched", 5'h0A, 16'h8000, 16'h8000);
    rd("fault cleared", 5'h0A, 16'h8000, 16'h0000);
  endtask
  initial begin
    pins(3);
    srst = 1'b0;
    t_reset();
    t_status();
    t_window();
    t_idle();
    t_fault();
    wrap_up();
  end
endmodule // testbench
